// >>> inc/lcd_port_regs.svh
`ifndef LCD_PORT_REGS_SVH
`define LCD_PORT_REGS_SVH
`define STAT_BUSY_BIT    7
`define STAT_ADC_BIT     6
`define STAT_OFF_BIT     5
`define STAT_RST_BIT     4
`define CMD_START_MASK   8'hE0
`define CMD_START_VAL    8'hC0
`define CMD_DISP_MASK    8'hFE
`define CMD_DISP_VAL     8'hAE
`define CMD_ADC_VAL      8'hA0
`define CMD_ALLON_VAL    8'hA4
`define CMD_PAGE_MASK    8'hFC
`define CMD_PAGE_VAL     8'hB8
`define CMD_RMW          8'hE0
`define CMD_END          8'hEE
`define CMD_SWRESET      8'hE2
`define COL_LIMIT        7'h50
`define PAGE_RESET       2'h3
`define LINE_LAST        5'h1F
`define INIT_TIME_NS     1000
`define CLK_PERIOD_NS    20
`define INIT_CYCLES      ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LVL_TOP          2'h3
`define LVL_MIDHI        2'h2
`define LVL_MIDLO        2'h1
`define LVL_GND          2'h0
`endif

// >>> inc/lcd_port_pkg.sv
package lcd_port_pkg;
  typedef enum logic [1:0] {
    CYC_DATA_RD, CYC_DATA_WR, CYC_STAT_RD, CYC_CMD_WR
  } cycle_t;
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } bus_drive_t;
endpackage

// >>> logic/lcd_host_port.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_port_regs.svh"

// picks one of four drive levels for one segment from its data bit and polarity
module seg_level_sel (
  input  wire logic       dataBit,
  input  wire logic       frm,
  output logic [1:0]      level
);
  always_comb begin
    case ({dataBit, frm})
      2'b11:   level = `LVL_TOP;
      2'b01:   level = `LVL_MIDHI;
      2'b10:   level = `LVL_GND;
      2'b00:   level = `LVL_MIDLO;
      default: level = `LVL_GND;
    endcase
  end
endmodule

module lcd_host_port #(
  parameter int NUM_SEG   = 80,
  parameter int INIT_CYC  = `INIT_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     cmd_data_select,
  input  wire logic                     chipSelectN,
  input  wire logic                     reset_and_bus_type_pin,
  input  wire logic                     strobeEnRd,
  input  wire logic                     dirRwWr,
  input  wire logic [7:0]               dataIn,
  output lcd_port_pkg::bus_drive_t      dataDrive,
  input  wire logic                     line_clock,
  input  wire logic                     frame_polarity,
  output logic [2*NUM_SEG-1:0]          segment_output,
  output logic [4:0]                    lineCount,
  output logic                          busy
);
  import lcd_port_pkg::*;

  logic [7:0] ram [0:4*NUM_SEG-1];

  // two-flop synchronisers; stage one is read only by stage two
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [6:0] s3_q;
  logic [7:0] d1_q;
  logic [7:0] d2_q;
  always_ff @(posedge clk) begin
    s1_q <= {frame_polarity, line_clock, reset_and_bus_type_pin,
             dirRwWr, strobeEnRd, chipSelectN, cmd_data_select};
    s2_q <= s1_q;
    s3_q <= s2_q;
    d1_q <= dataIn;
    d2_q <= d1_q;
  end
  logic sel, csN, stb, rw, resPin, lclk, frm;
  assign {frm, lclk, resPin, rw, stb, csN, sel} = s2_q;
  logic stbPrev, rwPrev, resPrev, lclkPrev, frmPrev;
  assign {frmPrev, lclkPrev, resPrev, rwPrev, stbPrev} = s3_q[6:2];

  logic mode68;
  assign mode68 = resPin;

  // access event and kind
  logic rdAct, rdStart, wrDone, isRd;
  always_comb begin
    if (mode68) begin
      rdAct   = !csN && stb && rw;
      rdStart = !csN && stb && !stbPrev && rw;
      wrDone  = !csN && !stb && stbPrev && !rw;
    end else begin
      rdAct   = !csN && !stb;
      rdStart = !csN && !stb && stbPrev;
      wrDone  = !csN && rw && !rwPrev;
    end
  end
  assign isRd = rdStart;

  cycle_t kind;
  always_comb begin
    if (sel)
      kind = isRd ? CYC_DATA_RD : CYC_DATA_WR;
    else
      kind = isRd ? CYC_STAT_RD : CYC_CMD_WR;
  end
  logic ev;
  assign ev = rdStart || wrDone;

  // initialization on reset pin edges
  logic resEdge;
  assign resEdge = resPin != resPrev;
  logic [15:0] initCnt_q;
  logic        swReset;
  logic        busyInt;
  assign swReset = ev && kind == CYC_CMD_WR && !busyInt
                   && d2_q == `CMD_SWRESET;
  always_ff @(posedge clk) begin
    if (rst || resEdge || swReset)
      initCnt_q <= 16'(INIT_CYC);
    else if (initCnt_q != 16'h0000)
      initCnt_q <= initCnt_q - 16'h0001;
  end
  assign busyInt = initCnt_q != 16'h0000;
  assign busy    = busyInt;
  logic hwInit;
  assign hwInit = rst || resEdge;

  logic       dispOff_q, adc_q, allOn_q, rmw_q;
  logic [1:0] page_q;
  logic [6:0] col_q;
  logic [4:0] startLine_q;
  logic [7:0] outLatch_q;
  logic [6:0] rmwCol_q;

  logic cmdOk;
  assign cmdOk = ev && kind == CYC_CMD_WR && !busyInt;

  always_ff @(posedge clk) begin
    if (hwInit) begin
      dispOff_q <= 1'b1;
      allOn_q   <= 1'b0;
      adc_q     <= 1'b0;
      rmw_q     <= 1'b0;
    end else if (cmdOk) begin
      if ((d2_q & `CMD_DISP_MASK) == `CMD_DISP_VAL)
        dispOff_q <= !d2_q[0];
      if ((d2_q & `CMD_DISP_MASK) == `CMD_ADC_VAL)
        adc_q <= d2_q[0];
      if ((d2_q & `CMD_DISP_MASK) == `CMD_ALLON_VAL)
        allOn_q <= d2_q[0];
      if (d2_q == `CMD_RMW)
        rmw_q <= 1'b1;
      if (d2_q == `CMD_END)
        rmw_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (hwInit || swReset)
      startLine_q <= 5'h00;
    else if (cmdOk && (d2_q & `CMD_START_MASK) == `CMD_START_VAL)
      startLine_q <= d2_q[4:0];
  end

  always_ff @(posedge clk) begin
    if (hwInit || swReset)
      page_q <= `PAGE_RESET;
    else if (cmdOk && (d2_q & `CMD_PAGE_MASK) == `CMD_PAGE_VAL)
      page_q <= d2_q[1:0];
  end

  logic dataEv;
  assign dataEv = ev && (kind == CYC_DATA_RD || kind == CYC_DATA_WR)
                  && !busyInt;
  logic [8:0] addr;
  assign addr = 9'(page_q * NUM_SEG) + 9'(col_q);

  always_ff @(posedge clk) begin
    if (hwInit)
      col_q <= 7'h00;
    else if (cmdOk && !d2_q[7])
      col_q <= d2_q[6:0];
    else if (cmdOk && d2_q == `CMD_END)
      col_q <= rmwCol_q;
    else if (dataEv && col_q != `COL_LIMIT &&
             !(rmw_q && kind == CYC_DATA_RD))
      col_q <= col_q + 7'h01;
  end

  always_ff @(posedge clk) begin
    if (cmdOk && d2_q == `CMD_RMW)
      rmwCol_q <= col_q;
  end

  always_ff @(posedge clk) begin
    if (dataEv && kind == CYC_DATA_WR && col_q != `COL_LIMIT)
      ram[addr] <= d2_q;
  end

  always_ff @(posedge clk) begin
    if (rst)
      outLatch_q <= 8'h00;
    else if (dataEv && kind == CYC_DATA_RD)
      outLatch_q <= ram[addr];
  end

  // bus output register
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[`STAT_BUSY_BIT] = busyInt;
    status[`STAT_ADC_BIT]  = !adc_q;
    status[`STAT_OFF_BIT]  = dispOff_q;
    status[`STAT_RST_BIT]  = busyInt;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      dataDrive <= '0;
    end else begin
      if (rdStart)
        dataDrive.dout <= sel ? outLatch_q : status;
      dataDrive.oe <= rdAct ? 8'hFF : 8'h00;
    end
  end

  // line pointer
  always_ff @(posedge clk) begin
    if (hwInit)
      lineCount <= 5'h00;
    else if (frm != frmPrev)
      lineCount <= startLine_q;
    else if (lclk != lclkPrev)
      lineCount <= (lineCount == `LINE_LAST) ? 5'h00
                                             : lineCount + 5'h01;
  end

  // display latch and level selection
  logic [NUM_SEG-1:0] lineBits_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      lineBits_q <= '0;
    end else if (lclk != lclkPrev) begin
      for (int i = 0; i < NUM_SEG; i++) begin
        logic [7:0] b;
        b = ram[9'(lineCount[4:3] * NUM_SEG) + 9'(i)];
        lineBits_q[i] <= allOn_q || (!dispOff_q && b[lineCount[2:0]]);
      end
    end
  end

  logic [2*NUM_SEG-1:0] segLevel;
  for (genvar g = 0; g < NUM_SEG; g++) begin : gSeg
    seg_level_sel i_lvl (
      .dataBit (lineBits_q[g]),
      .frm     (frm),
      .level   (segLevel[2*g +: 2])
    );
  end

  always_ff @(posedge clk) begin
    if (rst)
      segment_output <= '0;
    else
      segment_output <= segLevel;
  end
endmodule
`default_nettype wire

// >>> test/mpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module mpu_model (
  input  wire logic                     clk,
  input  wire logic                     busType,
  input  wire lcd_port_pkg::bus_drive_t drv,
  output logic                          sel,
  output logic                          csN,
  output logic                          en,
  output logic                          rw,
  output logic [7:0]                    din
);
  import lcd_port_pkg::*;
  logic [7:0] w;
  logic       wOe;
  // a released bus shows the inverse of the last host byte
  assign din = wOe ? w : (drv.oe == 8'hFF ? drv.dout : ~w);
  initial begin
    sel = 1'b0;
    csN = 1'b1;
    en = 1'b1;
    rw = 1'b1;
    w = 8'h00;
    wOe = 1'b0;
  end
  task cyc(input bit r, input bit a, input logic [7:0] d,
           input bit n, output logic [7:0] q);
    sel <= a;
    csN <= n;
    en <= ~busType;
    rw <= busType ? r : 1'b1;
    w <= d;
    wOe <= ~r;
    repeat (6) @(posedge clk);
    if (busType)
      en <= 1'b1;
    else if (r)
      en <= 1'b0;
    else
      rw <= 1'b0;
    repeat (6) @(posedge clk);
    q = din;
    en <= ~busType;
    rw <= busType ? r : 1'b1;
    repeat (6) @(posedge clk);
    csN <= 1'b1;
    wOe <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test/lcd_host_port_chk.sv
`timescale 1ns/100ps
`default_nettype none
module lcd_host_port_chk (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     chipSelectN,
  input wire logic                     reset_and_bus_type_pin,
  input wire logic                     strobeEnRd,
  input wire logic                     dirRwWr,
  input wire logic                     frame_polarity,
  input wire lcd_port_pkg::bus_drive_t dataDrive,
  input wire logic [4:0]               lineCount,
  input wire logic                     busy
);
  import lcd_port_pkg::*;
  wire       m68 = reset_and_bus_type_pin;
  wire [7:0] oe  = dataDrive.oe;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd80;
    !chipSelectN && !m68 && !strobeEnRd;
  endsequence
  sequence rd68;
    !chipSelectN && m68 && strobeEnRd && dirRwWr;
  endsequence
  sequence lineMoves;
    $stable(frame_polarity) [*8] ##0 ($changed(lineCount) && !busy);
  endsequence
  AST_RD80: assert property (rd80 [*4] |-> oe == 8'hFF)
    else $error("bus not driven on 80 read");
  AST_RD68: assert property (rd68 [*4] |-> oe == 8'hFF)
    else $error("bus not driven on 68 read");
  AST_WR80: assert property (
    (!m68 && strobeEnRd) [*4] |-> oe == 8'h00)
    else $error("bus driven without 80 read");
  AST_WR68: assert property (
    (m68 && !dirRwWr) [*4] |-> oe == 8'h00)
    else $error("bus driven on 68 write");
  AST_DESEL: assert property (chipSelectN [*4] |-> oe == 8'h00)
    else $error("bus driven while deselected");
  AST_WIDTH: assert property (oe == 8'h00 || oe == 8'hFF)
    else $error("partial bus drive");
  AST_INIT: assert property ($changed(m68) |-> ##[1:4] busy)
    else $error("no init after pin edge");
  AST_RSTB: assert property ($fell(rst) |-> ##[0:2] busy)
    else $error("no init after reset");
  AST_LINE: assert property (
    lineMoves |-> lineCount == $past(lineCount) + 5'h01)
    else $error("line counter step wrong");
endmodule
bind lcd_host_port lcd_host_port_chk u_chk (
  .clk(clk), .rst(rst), .chipSelectN(chipSelectN),
  .reset_and_bus_type_pin(reset_and_bus_type_pin),
  .strobeEnRd(strobeEnRd), .dirRwWr(dirRwWr),
  .frame_polarity(frame_polarity), .dataDrive(dataDrive),
  .lineCount(lineCount), .busy(busy));
`default_nettype wire

// >>> test/lcd_driver_host_port_line_counter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lcd_driver_host_port_line_counter_tb;
  import lcd_port_pkg::*;
  logic         clk, rst, pin, fp, lc, sel, csN, en, rw, busy;
  logic [7:0]   din, q;
  logic [4:0]   line;
  logic [159:0] seg;
  bus_drive_t   drv;
  int           failures, compares;
  lcd_host_port #(.INIT_CYC(80)) i_dut (
    .clk(clk), .rst(rst), .cmd_data_select(sel), .chipSelectN(csN),
    .reset_and_bus_type_pin(pin), .strobeEnRd(en), .dirRwWr(rw),
    .dataIn(din), .dataDrive(drv), .line_clock(lc),
    .frame_polarity(fp), .segment_output(seg), .lineCount(line),
    .busy(busy));
  mpu_model m (.clk(clk), .busType(pin), .drv(drv), .sel(sel),
    .csN(csN), .en(en), .rw(rw), .din(din));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task idle;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, busy}, 8'h00);
    if (busy !== 1'b0)
      stop_test;
  endtask
  task tog(input bit f);
    if (f)
      fp <= ~fp;
    else
      lc <= ~lc;
    repeat (6) @(posedge clk);
  endtask
  task wr(input bit a, input logic [7:0] d);
    m.cyc(1'b0, a, d, 1'b0, q);
  endtask
  task rd(input bit a);
    m.cyc(1'b1, a, 8'h00, 1'b0, q);
  endtask
  task s_stat;
    chk({6'h00, seg[1:0]}, 8'h01);
    rd(1'b0);
    chk(q, 8'h60);
    wr(1'b0, 8'hAF);
    wr(1'b0, 8'hA1);
    rd(1'b0);
    chk(q, 8'h00);
  endtask
  task s_ram;
    wr(1'b0, 8'h4E);
    wr(1'b1, 8'hA5);
    wr(1'b1, 8'h3C);
    wr(1'b1, 8'h5A);
    wr(1'b0, 8'h4E);
    rd(1'b1);
    rd(1'b1);
    chk(q, 8'hA5);
    rd(1'b1);
    chk(q, 8'h3C);
  endtask
  task s_line;
    wr(1'b0, 8'hC5);
    tog(1'b1);
    chk({3'h0, line}, 8'h05);
    chk({6'h00, seg[1:0]}, 8'h02);
    tog(1'b0);
    tog(1'b0);
    chk({3'h0, line}, 8'h07);
    wr(1'b0, 8'hDF);
    tog(1'b1);
    chk({3'h0, line}, 8'h1F);
    tog(1'b0);
    chk({3'h0, line}, 8'h00);
    m.cyc(1'b0, 1'b0, 8'hC3, 1'b1, q);
    tog(1'b1);
    chk({3'h0, line}, 8'h1F);
  endtask
  task s_mode;
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    rd(1'b0);
    chk(q & 8'h80, 8'h80);
    wr(1'b0, 8'hC9);
    idle;
    tog(1'b1);
    chk({3'h0, line}, 8'h00);
    rd(1'b0);
    chk(q, 8'h60);
    wr(1'b0, 8'hC9);
    tog(1'b1);
    chk({3'h0, line}, 8'h09);
  endtask
  initial begin
    rst = 1'b1;
    pin = 1'b0;
    fp = 1'b0;
    lc = 1'b0;
    failures = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    idle;
    s_stat;
    s_ram;
    s_line;
    s_mode;
    stop_test;
  end
endmodule
`default_nettype wire
